/* File: src/uio_pkg.sv */
// Constants for the unit I/O bus data path
package uio_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] A_INSTR = 3'h0;
    localparam logic [2:0] A_WORD2 = 3'h1;
    localparam logic [2:0] A_ACC   = 3'h2;
    localparam logic [2:0] A_STAT  = 3'h3;
    localparam logic [2:0] A_PC    = 3'h4;
    localparam logic [2:0] A_TREG  = 3'h5;
    localparam logic [2:0] A_IR    = 3'h6;
    localparam logic [2:0] A_BT    = 3'h7;
    // ----------------------------------------------------------------
    // First word fields (bit 0 of the word is the lsb)
    // ----------------------------------------------------------------
    localparam int W_BIT    = 8;
    localparam int M_BIT    = 9;
    localparam int I_BIT    = 10;
    localparam int R_BIT    = 11;
    localparam int KIND_LSB = 12;
    localparam int CHAR_W   = 7;
    // ----------------------------------------------------------------
    // Instruction kinds
    // ----------------------------------------------------------------
    localparam logic [2:0] K_CMD  = 3'h0;
    localparam logic [2:0] K_TEST = 3'h1;
    localparam logic [2:0] K_MOP  = 3'h2;
    localparam logic [2:0] K_AOP  = 3'h3;
    localparam logic [2:0] K_MIP  = 3'h4;
    localparam logic [2:0] K_AIP  = 3'h5;
    // ----------------------------------------------------------------
    // Fixed locations, forced codes and reset values
    // ----------------------------------------------------------------
    localparam logic [14:0] INT0_ADDR  = 15'h0002;
    localparam logic [14:0] INT1_ADDR  = 15'h0003;
    localparam logic [15:0] SPB_IND    = 16'hf400;
    localparam logic [14:0] BT_CNT_LOC = 15'h0010;
    localparam logic [14:0] BT_ADR_LOC = 15'h0011;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS       = 20;
    localparam int MEM_CYC_NS   = 160;
    localparam int MEM_CYC_CLKS = MEM_CYC_NS / CLK_NS;
    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_IND, S_TEST, S_E1, S_AIP2, S_INT, S_BTC, S_BTA, S_BTW
    } uio_state_t;
endpackage

/* File: src/uio_bus.sv */
// Mainframe side sequencer of the daisy-chained unit I/O bus
//
// Functional notes
// - Wait flag 0 runs skip mode, 1 runs wait mode
// - Addressing flag 0 uses immediate second word, 1 fetches address
// - High-address flag appends fifteenth bit to 14-bit address
// - Memory input stores word; character units fill 7 low bits
// - All units share one parallel cable and look identical
// - Command, test, memory output word held whole cycle on drivers
// - Outgoing word and controls go to all units together
// - Accumulator output routes accumulator to cable drivers
// - Memory input gates unit data-in word into memory data
// - Accumulator input goes via temporary register into accumulator
// - Interrupt forces its fixed address into temporary address register
// - Interrupt forces indirect store-place-branch code into instruction
// - Block transfer fetches count and address, writes address back
// - Unit number bits 0-5 stay stable on the bus all instruction
// - Sync plus ready level; skip mode skips on high, advances on low
// - Wait mode repeats test cycle until ready, then advances once
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module uio_bus #(
    parameter int CYC_CLKS = uio_pkg::MEM_CYC_CLKS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Memory module port, read data one clock after mem_rd
    output logic      [14:0] mem_addr,
    output logic             mem_rd,
    input  wire logic [15:0] mem_rdata,
    output logic             mem_wr,
    output logic      [15:0] mem_wdata,
    // Unit I/O bus
    output logic      [5:0]  unit_no,
    output logic      [15:0] bus_out,
    output logic             bus_out_en,
    output logic             ctl_test,
    output logic             ctl_exec,
    output logic      [2:0]  ctl_kind,
    input  wire logic        ret_sync,
    input  wire logic        ret_ready,
    input  wire logic        sense_ret,
    input  wire logic        char_unit,
    input  wire logic [15:0] data_in,
    // Interrupts and block transfer
    input  wire logic [1:0]  int_req,
    output logic      [1:0]  int_ack,
    input  wire logic        bt_start,
    input  wire logic        bt_store
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (CYC_CLKS < 4 || CYC_CLKS > 255) begin : g_chk
        $error("CYC_CLKS out of range");
    end

    uio_pkg::uio_state_t st_r, st_nxt;
    logic [7:0]  cnt_r;
    logic [15:0] ir_r, word2_r, mdr_r, acc_r, tmp_r, bt_cnt_r;
    logic [14:0] pc_r, t_r, bt_adr_r;
    logic        go_r, sync_r, rdy_r, sense_r, btgo_r, btwb_r;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire       tick     = (cnt_r == 8'(CYC_CLKS - 1));
    wire       ph_rd    = (cnt_r == 8'h00);
    wire       ph_cap   = (cnt_r == 8'h01);
    wire       f_wait   = ir_r[uio_pkg::W_BIT];
    wire       f_addr   = ir_r[uio_pkg::I_BIT];
    wire       f_merge  = ir_r[uio_pkg::R_BIT];
    wire [2:0] kind     = ir_r[uio_pkg::KIND_LSB +: 3];
    wire [14:0] ea      = {ir_r[uio_pkg::M_BIT], word2_r[13:0]};
    wire       busy     = (st_r != uio_pkg::S_IDLE);
    wire       io_st    = (st_r == uio_pkg::S_IND) || (st_r == uio_pkg::S_TEST)
                       || (st_r == uio_pkg::S_E1) || (st_r == uio_pkg::S_AIP2);
    wire       in_e1    = (st_r == uio_pkg::S_E1);
    wire       k_out    = (kind == uio_pkg::K_CMD) || (kind == uio_pkg::K_TEST)
                       || (kind == uio_pkg::K_MOP);
    wire       k_aop    = (kind == uio_pkg::K_AOP);
    wire       k_mip    = (kind == uio_pkg::K_MIP);
    wire       k_aip    = (kind == uio_pkg::K_AIP);
    wire       int_pend = |int_req;
    wire       rd_st    = (st_r == uio_pkg::S_IND) || (st_r == uio_pkg::S_BTC)
                       || (st_r == uio_pkg::S_BTA);
    wire       wr_instr = reg_wr && reg_addr == uio_pkg::A_INSTR && !busy && !go_r;
    wire       sync_now = sync_r || ret_sync;
    wire       rdy_now  = sync_r ? rdy_r : ret_ready;
    wire       done_io  = tick && ((in_e1 && !k_aip) || st_r == uio_pkg::S_AIP2);
    wire [14:0] pc_step = (f_wait ? 15'h0001 : 15'h0002);
    wire [15:0] char_in = {{(16 - uio_pkg::CHAR_W){1'b0}}, data_in[uio_pkg::CHAR_W-1:0]};
    wire [15:0] aip_val = f_merge ? {acc_r[15:8], tmp_r[7:0]} : tmp_r;

    // ----------------------------------------------------------------
    // Memory and unit bus outputs
    // ----------------------------------------------------------------
    assign mem_rd     = rd_st && ph_rd;
    assign mem_wr     = ((in_e1 && k_mip) || st_r == uio_pkg::S_BTW) && tick;
    assign mem_addr   = (st_r == uio_pkg::S_BTC) ? uio_pkg::BT_CNT_LOC :
                        (st_r == uio_pkg::S_BTA || st_r == uio_pkg::S_BTW) ?
                        uio_pkg::BT_ADR_LOC : ea;
    // Character units fill only the low bits, the rest of the cell is cleared
    assign mem_wdata  = (st_r == uio_pkg::S_BTW) ? {1'b0, bt_adr_r} :
                        (char_unit ? char_in : data_in);
    // Unit number comes straight from the held instruction word
    assign unit_no    = ir_r[5:0];
    assign bus_out    = k_aop ? acc_r : mdr_r;
    assign bus_out_en = in_e1 && (k_out || k_aop);
    assign ctl_test   = (st_r == uio_pkg::S_TEST);
    assign ctl_exec   = in_e1;
    assign ctl_kind   = kind;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            uio_pkg::S_IDLE: begin
                if (int_pend) begin
                    st_nxt = uio_pkg::S_INT;
                end else if (go_r) begin
                    st_nxt = f_addr ? uio_pkg::S_IND : uio_pkg::S_TEST;
                end else if (btgo_r) begin
                    st_nxt = uio_pkg::S_BTC;
                end else if (btwb_r) begin
                    st_nxt = uio_pkg::S_BTW;
                end
            end
            uio_pkg::S_IND:  st_nxt = uio_pkg::S_TEST;
            uio_pkg::S_TEST: begin
                if (sync_now) begin
                    if (rdy_now) begin
                        st_nxt = uio_pkg::S_E1;
                    end else if (!f_wait) begin
                        st_nxt = uio_pkg::S_IDLE;
                    end
                end
            end
            uio_pkg::S_E1:   st_nxt = k_aip ? uio_pkg::S_AIP2 : uio_pkg::S_IDLE;
            uio_pkg::S_BTC:  st_nxt = uio_pkg::S_BTA;
            default:         st_nxt = uio_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r  <= uio_pkg::S_IDLE;
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
            if (tick) begin
                st_r <= st_nxt;
            end
        end
    end

    // Return sync seen in the address fetch is kept past its end, until the following test cycle ends
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_r  <= 1'b0;
            rdy_r   <= 1'b0;
            sense_r <= 1'b0;
        end else if (tick && st_r != uio_pkg::S_IND) begin
            sync_r <= 1'b0;
        end else if (ret_sync && (st_r == uio_pkg::S_IND || ctl_test)) begin
            sync_r  <= 1'b1;
            rdy_r   <= ret_ready;
            sense_r <= sense_ret;
        end
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ir_r    <= uio_pkg::RST_WORD;
            word2_r <= uio_pkg::RST_WORD;
            mdr_r   <= uio_pkg::RST_WORD;
            go_r    <= 1'b0;
        end else begin
            if (wr_instr) begin
                ir_r <= reg_wdata;
                go_r <= 1'b1;
            end else if (st_r == uio_pkg::S_INT && tick) begin
                ir_r <= uio_pkg::SPB_IND;
            end
            if (reg_wr && reg_addr == uio_pkg::A_WORD2 && !busy) begin
                word2_r <= reg_wdata;
            end
            if (tick && st_r == uio_pkg::S_IDLE && go_r && !int_pend) begin
                go_r  <= 1'b0;
                mdr_r <= word2_r;
            end else if (st_r == uio_pkg::S_IND && ph_cap) begin
                mdr_r <= mem_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_r <= uio_pkg::RST_WORD;
            tmp_r <= uio_pkg::RST_WORD;
            pc_r  <= 15'h0000;
        end else begin
            if (reg_wr && reg_addr == uio_pkg::A_ACC && !busy) begin
                acc_r <= reg_wdata;
            end else if (st_r == uio_pkg::S_AIP2 && tick) begin
                acc_r <= aip_val;
            end
            if (in_e1 && k_aip && tick) begin
                tmp_r <= data_in;
            end
            if (done_io) begin
                pc_r <= pc_r + pc_step;
            end else if (ctl_test && tick && sync_now && !rdy_now && !f_wait) begin
                pc_r <= pc_r + 15'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt forcing and block transfer pointers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            t_r      <= 15'h0000;
            int_ack  <= 2'b00;
            bt_cnt_r <= uio_pkg::RST_WORD;
            bt_adr_r <= 15'h0000;
            btgo_r   <= 1'b0;
            btwb_r   <= 1'b0;
        end else begin
            int_ack <= 2'b00;
            if (st_r == uio_pkg::S_INT && tick) begin
                t_r     <= int_req[0] ? uio_pkg::INT0_ADDR : uio_pkg::INT1_ADDR;
                int_ack <= int_req[0] ? 2'b01 : {int_req[1], 1'b0};
            end else if (f_addr && io_st && ph_cap && st_r == uio_pkg::S_IND) begin
                t_r <= ea;
            end
            // A new request wins over the clear of the one just taken
            if (bt_start) begin
                btgo_r <= 1'b1;
            end else if (st_r == uio_pkg::S_BTC) begin
                btgo_r <= 1'b0;
            end
            if (bt_store) begin
                btwb_r <= 1'b1;
            end else if (st_r == uio_pkg::S_BTW) begin
                btwb_r <= 1'b0;
            end
            if (st_r == uio_pkg::S_BTC && ph_cap) begin
                bt_cnt_r <= mem_rdata;
            end
            if (st_r == uio_pkg::S_BTA && ph_cap) begin
                bt_adr_r <= mem_rdata[14:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    wire [15:0] stat = {8'h00, char_unit, kind, sense_r, rdy_r,
                        ctl_test && f_wait, busy};
    logic [15:0] rd_mux;
    always_comb begin
        case (reg_addr)
            uio_pkg::A_INSTR: rd_mux = ir_r;
            uio_pkg::A_WORD2: rd_mux = word2_r;
            uio_pkg::A_ACC:   rd_mux = acc_r;
            uio_pkg::A_STAT:  rd_mux = stat;
            uio_pkg::A_PC:    rd_mux = {1'b0, pc_r};
            uio_pkg::A_TREG:  rd_mux = {1'b0, t_r};
            uio_pkg::A_IR:    rd_mux = bt_cnt_r;
            default:          rd_mux = {1'b0, bt_adr_r};
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_test_end;
        ctl_test && tick && sync_now;
    endsequence

    property p_skip_low;
        @(posedge clk_sys) disable iff (rst)
        (s_test_end and (!rdy_now && !f_wait)) |=> st_r == uio_pkg::S_IDLE;
    endproperty
    a_skip_low: assert property (p_skip_low) else $error("skip low");

    property p_wait_repeat;
        @(posedge clk_sys) disable iff (rst)
        (s_test_end and (!rdy_now && f_wait)) |=> st_r == uio_pkg::S_TEST;
    endproperty
    a_wait_repeat: assert property (p_wait_repeat) else $error("wait");

    property p_mode;
        @(posedge clk_sys) disable iff (rst)
        tick && st_r == uio_pkg::S_IDLE && go_r && !int_pend |=>
        st_r == (f_addr ? uio_pkg::S_IND : uio_pkg::S_TEST);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");

    property p_ea;
        @(posedge clk_sys) disable iff (rst)
        mem_rd && st_r == uio_pkg::S_IND |->
        mem_addr[14] == ir_r[uio_pkg::M_BIT];
    endproperty
    a_ea: assert property (p_ea) else $error("ea");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        in_e1 && k_out && ph_rd |-> bus_out_en ##1 $stable(bus_out) && bus_out_en;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");

    property p_aop;
        @(posedge clk_sys) disable iff (rst)
        in_e1 && k_aop |-> bus_out == acc_r && bus_out_en;
    endproperty
    a_aop: assert property (p_aop) else $error("aop");

    property p_mip;
        @(posedge clk_sys) disable iff (rst)
        mem_wr && in_e1 && char_unit |-> mem_wdata[15:uio_pkg::CHAR_W] == '0;
    endproperty
    a_mip: assert property (p_mip) else $error("mip");

    property p_unit;
        @(posedge clk_sys) disable iff (rst)
        io_st && $past(io_st) |-> $stable(unit_no);
    endproperty
    a_unit: assert property (p_unit) else $error("unit");

    property p_int;
        @(posedge clk_sys) disable iff (rst)
        st_r == uio_pkg::S_INT && tick |=> ir_r == uio_pkg::SPB_IND && int_ack != 2'b00;
    endproperty
    a_int: assert property (p_int) else $error("int");

    property p_aip;
        @(posedge clk_sys) disable iff (rst)
        st_r == uio_pkg::S_AIP2 && tick && !f_merge |=> acc_r == $past(tmp_r);
    endproperty
    a_aip: assert property (p_aip) else $error("aip");

endmodule // uio_bus

/* File: verification/uio_unit_model.sv */
// Behavioural model of one daisy-chained peripheral unit
`timescale 1ns/100ps
module uio_unit_model #(
    parameter logic [5:0] CODE = 6'h2a
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Shared bus from the mainframe
    input  wire logic [5:0]  unit_no,
    input  wire logic        ctl_test,
    input  wire logic        ctl_exec,
    input  wire logic [15:0] bus_out,
    input  wire logic        bus_out_en,
    // Unit condition set by the bench
    input  wire logic        has_word,
    input  wire logic [15:0] word,
    input  wire logic        sense,
    // Return lines
    output logic             ret_sync,
    output logic             ret_ready,
    output logic             sense_ret,
    output logic      [15:0] data_in,
    // Unit side results
    output logic      [15:0] out_reg,
    output logic      [7:0]  got
);
    logic [1:0]  cnt_r;
    logic [15:0] last_r;
    logic        exec_q;
    wire         sel = (unit_no == CODE);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r    <= 2'h0;
            ret_sync <= 1'b0;
            out_reg  <= 16'h0000;
            got      <= 8'h00;
            last_r   <= 16'h0000;
            exec_q   <= 1'b0;
        end else begin
            exec_q   <= ctl_exec;
            cnt_r    <= (ctl_test && sel) ? cnt_r + 2'h1 : 2'h0;
            ret_sync <= ctl_test && sel && (cnt_r == 2'h1);
            // Take the word once per execute cycle, at its first clock
            if (ctl_exec && !exec_q && bus_out_en && sel) begin
                out_reg <= bus_out;
                got     <= got + 8'h01;
            end
            if (sel) begin
                last_r <= data_in;
            end
        end
    end
    // A released data line shows the inverse of its last value, never a held copy
    assign ret_ready = sel && ret_sync && has_word;
    assign sense_ret = sel ? sense : 1'b0;
    assign data_in   = sel ? word : ~last_r;
endmodule // uio_unit_model

/* File: verification/tb.sv */
// Self-checking testbench of the unit I/O bus data path
`timescale 1ns/100ps
module tb;
    localparam int         CYC  = 4;
    localparam logic [5:0] CODE = 6'h2a;
    logic        clk_sys = 1'b0, rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, mem_rdata = 16'h0000, u_word = 16'h0000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, char_unit = 1'b0, has_word = 1'b0;
    logic        bt_start = 1'b0, bt_store = 1'b0, sense = 1'b0;
    logic [1:0]  int_req = 2'h0, int_ack;
    logic [15:0] reg_rdata, mem_wdata, bus_out, data_in, u_out, s, e;
    logic [14:0] mem_addr;
    logic [5:0]  unit_no;
    logic [2:0]  ctl_kind;
    logic [7:0]  u_got;
    logic        mem_rd, mem_wr, bus_out_en, ctl_test, ctl_exec;
    logic        ret_sync, ret_ready, sense_ret;
    logic [15:0] mem [0:32767];
    logic [15:0] e_acc;
    int          seed = 32'h1486, e_pc = 0, e_got = 0, n, cyc = 0;
    int          mismatches = 0, comparisons = 0;
    // ----------------------------------------------------------------
    // Design, unit and memory
    // ----------------------------------------------------------------
    uio_bus #(.CYC_CLKS(CYC)) i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .unit_no(unit_no), .bus_out(bus_out),
        .bus_out_en(bus_out_en), .ctl_test(ctl_test), .ctl_exec(ctl_exec),
        .ctl_kind(ctl_kind), .ret_sync(ret_sync), .ret_ready(ret_ready),
        .sense_ret(sense_ret), .char_unit(char_unit), .data_in(data_in),
        .int_req(int_req), .int_ack(int_ack), .bt_start(bt_start), .bt_store(bt_store));
    uio_unit_model #(.CODE(CODE)) u_unit (.clk_sys(clk_sys), .rst(rst),
        .unit_no(unit_no), .ctl_test(ctl_test), .ctl_exec(ctl_exec), .bus_out(bus_out),
        .bus_out_en(bus_out_en), .has_word(has_word), .word(u_word), .sense(sense),
        .ret_sync(ret_sync), .ret_ready(ret_ready), .sense_ret(sense_ret),
        .data_in(data_in), .out_reg(u_out), .got(u_got));
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (mem_rd) mem_rdata <= mem[mem_addr];
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
        comparisons++;
        if (g !== ex) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic run(input logic [2:0] k, input logic w, i, m, r,
                       input logic [15:0] w2, input logic rdy, ch);
        logic [15:0] v, ex, st;
        logic [14:0] ea;
        v  = 16'($random(seed));
        ea = {m, w2[13:0]};
        ex = i ? mem[ea] : w2;
        u_word <= v; has_word <= rdy; char_unit <= ch; sense <= v[0];
        wr(uio_pkg::A_WORD2, w2);
        wr(uio_pkg::A_INSTR, {1'b0, k, r, i, m, w, 2'h0, CODE});
        repeat (4 * CYC) @(posedge clk_sys);
        if (!rdy && w) begin
            repeat (4 * CYC) @(posedge clk_sys);
            has_word <= 1'b1;
        end
        n = 0;
        do begin rd(uio_pkg::A_STAT, st); n++; end while (st[0] !== 1'b0 && n < 100);
        chk("status", {8'h00, ch, k, v[0], rdy || w, 2'b00}, st);
        chk("ctl kind", {13'h0000, k}, {13'h0000, ctl_kind});
        if (rdy || w) begin
            if (k == uio_pkg::K_MIP) begin
                chk("stored word", ch ? {9'h000, v[6:0]} : v, mem[ea]);
            end else if (k == uio_pkg::K_AIP) begin
                e_acc = r ? {e_acc[15:8], v[7:0]} : v;
                rd(uio_pkg::A_ACC, st);
                chk("accumulator", e_acc, st);
            end else begin
                e_got++;
                chk("unit word", (k == uio_pkg::K_AOP) ? e_acc : ex, u_out);
            end
        end
        e_pc += (rdy && !w) ? 2 : 1;
        rd(uio_pkg::A_PC, st);
        chk("pc", 16'(e_pc), st);
        chk("unit captures", 16'(e_got), {8'h00, u_got});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        for (int j = 0; j < 32768; j++) mem[j] = 16'(j * 7 + 3);
        mem[uio_pkg::INT0_ADDR] = 16'h0100;
        mem[uio_pkg::INT1_ADDR] = 16'h0200;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd(uio_pkg::A_STAT, s);
        chk("status", uio_pkg::RST_WORD, s);
        rd(uio_pkg::A_PC, s);
        chk("pc", uio_pkg::RST_WORD, s);
        e_acc = 16'($random(seed));
        wr(uio_pkg::A_ACC, e_acc);
        for (int k = 0; k < 6; k++) run(3'(k), 0, k == 2, k[0], 0, 16'($random(seed)), 1, 0);
        run(uio_pkg::K_MIP, 0, 0, 1, 0, 16'($random(seed)), 1, 1);
        run(uio_pkg::K_AIP, 0, 0, 0, 1, 16'($random(seed)), 1, 0);
        run(uio_pkg::K_MOP, 0, 1, 0, 0, 16'($random(seed)), 0, 0);
        run(uio_pkg::K_AOP, 1, 0, 0, 0, 16'($random(seed)), 0, 0);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_sys);
            int_req <= b ? 2'h2 : 2'h1;
            n = 0;
            do begin @(posedge clk_sys); #1 n++; end while (int_ack[b] !== 1'b1 && n < 50);
            chk("int ack", 16'h0001, {15'h0000, int_ack[b]});
            @(posedge clk_sys);
            int_req <= 2'h0;
            rd(uio_pkg::A_TREG, s);
            chk("t register", {1'b0, b ? uio_pkg::INT1_ADDR : uio_pkg::INT0_ADDR}, s);
            rd(uio_pkg::A_INSTR, s);
            chk("forced code", uio_pkg::SPB_IND, s);
        end
        e = mem[uio_pkg::BT_ADR_LOC];
        @(posedge clk_sys) bt_start <= 1'b1;
        @(posedge clk_sys) bt_start <= 1'b0;
        repeat (4 * CYC) @(posedge clk_sys);
        rd(uio_pkg::A_BT, s);
        chk("bt address", {1'b0, e[14:0]}, {1'b0, s[14:0]});
        rd(uio_pkg::A_IR, s);
        chk("bt count", mem[uio_pkg::BT_CNT_LOC], s);
        mem[uio_pkg::BT_ADR_LOC] = 16'h0000;
        @(posedge clk_sys) bt_store <= 1'b1;
        @(posedge clk_sys) bt_store <= 1'b0;
        repeat (4 * CYC) @(posedge clk_sys);
        chk("bt store", {1'b0, e[14:0]}, {1'b0, mem[uio_pkg::BT_ADR_LOC][14:0]});
        conclude();
    end
endmodule // tb
